// >>> hdl/rx_ctrl_pkg.sv
// Package with the register map, field positions and timing of the receive control block.
package rx_ctrl_pkg;

    // Byte addresses of the registers on the Avalon-MM slave.
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RECEIVE_DATA = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // Field positions in receive_control_status.
    localparam int NINE_BIT_POS = 6;
    localparam int SINGLE_POS = 5;
    localparam int CONTINUOUS_POS = 4;
    localparam int ADDRESS_DETECT_POS = 3;
    localparam int FRAMING_POS = 2;
    localparam int OVERRUN_POS = 1;
    localparam int NINTH_BIT_POS = 0;

    // Field positions in the mode register.
    localparam int SYNC_MODE_POS = 0;
    localparam int MASTER_POS = 1;

    // Field positions in the interrupt status and mask registers.
    localparam int IRQ_WORD_POS = 0;
    localparam int IRQ_FRAMING_POS = 1;
    localparam int IRQ_OVERRUN_POS = 2;

    // Values after reset.
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Serial timing: one bit lasts BIT_TIME_NS at a clock of CLK_PERIOD_NS.
    localparam int CLK_PERIOD_NS = 25;
    localparam int BIT_TIME_NS = 400;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam logic [7:0] BIT_LOAD = 8'(BIT_CYCLES - 1);
    localparam logic [7:0] HALF_LOAD = 8'(HALF_CYCLES - 1);

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

endpackage

// >>> hdl/serial_shift_receiver.sv
// Serial shift engine that assembles 8- or 9-bit words, asynchronous or clocked.
`timescale 1ns/10ps
`default_nettype none
module serial_shift_receiver (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Configuration.
    input wire logic enable,
    input wire logic sync_mode,
    input wire logic master,
    input wire logic nine_bit,
    // Serial pins.
    input wire logic data_in,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Completed word.
    output logic word_done,
    output logic [8:0] word,
    output logic frame_error
);
    rx_ctrl_pkg::rx_state_t state;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic sclk_prev;

    wire cnt_zero = cnt == 8'h00;
    wire last_bit = bitn == (nine_bit ? 4'h8 : 4'h7);
    wire slave_edge = sclk_in & ~sclk_prev;
    wire master_edge = cnt_zero & ~sclk_out;
    wire sync_sample = master ? master_edge : slave_edge;
    wire [8:0] next_shreg = {data_in, shreg[8:1]};
    wire [8:0] aligned = nine_bit ? shreg : {1'b0, shreg[8:1]};
    wire [8:0] next_aligned = nine_bit ? next_shreg : {1'b0, next_shreg[8:1]};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= rx_ctrl_pkg::RX_IDLE;
            cnt <= 8'h00;
            bitn <= 4'h0;
            shreg <= 9'h000;
            sclk_prev <= 1'b0;
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            word_done <= 1'b0;
            word <= 9'h000;
            frame_error <= 1'b0;
        end else if (!enable) begin
            // A disabled receiver abandons any partial word.
            state <= rx_ctrl_pkg::RX_IDLE;
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            word_done <= 1'b0;
            sclk_prev <= sclk_in;
        end else begin
            word_done <= 1'b0;
            sclk_prev <= sclk_in;
            sclk_oe <= sync_mode & master;
            unique case (state)
                rx_ctrl_pkg::RX_IDLE: begin
                    sclk_out <= 1'b0;
                    bitn <= 4'h0;
                    if (sync_mode) begin
                        state <= rx_ctrl_pkg::RX_DATA;
                        cnt <= rx_ctrl_pkg::HALF_LOAD;
                    end else if (!data_in) begin
                        state <= rx_ctrl_pkg::RX_START;
                        cnt <= rx_ctrl_pkg::HALF_LOAD;
                    end
                end
                rx_ctrl_pkg::RX_START: begin
                    // Start bit is checked mid-bit so a glitch is not taken for a frame.
                    if (!cnt_zero) begin
                        cnt <= cnt - 8'h01;
                    end else if (!data_in) begin
                        state <= rx_ctrl_pkg::RX_DATA;
                        cnt <= rx_ctrl_pkg::BIT_LOAD;
                    end else begin
                        state <= rx_ctrl_pkg::RX_IDLE;
                    end
                end
                rx_ctrl_pkg::RX_DATA: begin
                    if (sync_mode) begin
                        if (master) begin
                            cnt <= cnt_zero ? rx_ctrl_pkg::HALF_LOAD : cnt - 8'h01;
                            sclk_out <= cnt_zero ? ~sclk_out : sclk_out;
                        end
                        if (sync_sample) begin
                            shreg <= next_shreg;
                            bitn <= bitn + 4'h1;
                            if (last_bit) begin
                                word <= next_aligned;
                                word_done <= 1'b1;
                                frame_error <= 1'b0;
                                state <= rx_ctrl_pkg::RX_IDLE;
                            end
                        end
                    end else if (cnt_zero) begin
                        shreg <= next_shreg;
                        cnt <= rx_ctrl_pkg::BIT_LOAD;
                        bitn <= bitn + 4'h1;
                        if (last_bit) begin
                            state <= rx_ctrl_pkg::RX_STOP;
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                rx_ctrl_pkg::RX_STOP: begin
                    if (cnt_zero) begin
                        word <= aligned;
                        frame_error <= ~data_in;
                        word_done <= 1'b1;
                        state <= rx_ctrl_pkg::RX_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hdl/serial_receive_control_status.sv
// Receive control and status register block with Avalon-MM slave and interrupt.
//
// Contract
// [R1] The single-receive enable starts exactly one word, only in synchronous master mode.
// [R2] In synchronous master mode hardware clears the single-receive enable after the word.
// [R3] In asynchronous mode the continuous-receive enable switches the receiver on and off.
// [R4] In synchronous mode continuous receive runs until cleared and overrides single receive.
// [R5] With 9-bit asynchronous address detection only words with the ninth bit set are taken.
// [R6] Without address detection every word is taken and the ninth bit is kept as parity.
// [R7] Address detection is ignored in 8-bit asynchronous and in synchronous mode.
// [R8] The framing flag is set by a framing error and updated with the next word loaded.
// [R9] The overrun flag is set on overrun and cleared only by clearing continuous receive.
// [R10] A word completing while the buffer is still unread is an overrun and is discarded.
// [R11] The nine-bit select chooses 9-bit or 8-bit words and with it address detection.
// [R12] Parity in the ninth bit is computed and checked by software, not by hardware.
`timescale 1ns/10ps
`default_nettype none
module serial_receive_control_status (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial receive line and synchronous clock pin.
    input wire logic rx_data_in,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Interrupt.
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic nine_bit_receive_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic received_ninth_bit;
    logic sync_mode;
    logic master;
    logic [7:0] receive_data_register;
    logic buffer_full;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    logic word_done;
    logic [8:0] word;
    logic frame_error;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Waitrequest drops for one cycle after a request is seen; the access
    // takes effect at the edge that ends that cycle.
    wire request = read | write;
    wire accept = request & ~waitrequest;
    wire wr_accept = write & accept;
    wire rd_accept = read & accept;

    wire sel_control = address == rx_ctrl_pkg::ADDR_CONTROL_STATUS;
    wire sel_data = address == rx_ctrl_pkg::ADDR_RECEIVE_DATA;
    wire sel_mode = address == rx_ctrl_pkg::ADDR_MODE;
    wire sel_status = address == rx_ctrl_pkg::ADDR_IRQ_STATUS;
    wire sel_mask = address == rx_ctrl_pkg::ADDR_IRQ_MASK;

    wire wr_control = wr_accept & sel_control;
    wire wr_mode = wr_accept & sel_mode;
    wire wr_status = wr_accept & sel_status;
    wire wr_mask = wr_accept & sel_mask;
    wire rd_data = rd_accept & sel_data;

    wire [7:0] control_view = {
        1'b0,
        nine_bit_receive_select,
        single_receive_enable,
        continuous_receive_enable,
        address_detect_enable,
        framing_error_flag,
        overrun_error_flag,
        received_ninth_bit
    };

    wire [31:0] read_mux =
        sel_control ? {24'h000000, control_view} :
        sel_data ? {24'h000000, receive_data_register} :
        sel_mode ? {30'h0, master, sync_mode} :
        sel_status ? {29'h0, irq_status} :
        sel_mask ? {29'h0, irq_mask} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver enable and word acceptance.

    wire sync_master = sync_mode & master;
    wire single_active = sync_master & single_receive_enable; // see [R1]
    // Continuous receive overrides single receive in every mode.
    wire receiver_on = continuous_receive_enable | single_active; // see [R3] see [R4]

    // Address detection only means something for 9-bit asynchronous words.
    wire address_filter = ~sync_mode & nine_bit_receive_select
        & address_detect_enable; // see [R7] see [R11]
    wire word_wanted = ~address_filter | word[8]; // see [R5] see [R6]
    wire word_taken = word_done & word_wanted;
    wire overrun_event = word_taken & buffer_full; // see [R10]
    wire load_event = word_taken & ~buffer_full;
    wire framing_event = load_event & frame_error;

    ////////////////////////////////////////////////////////////////////////////////
    // Next values of the control fields.

    wire next_single =
        wr_control ? writedata[rx_ctrl_pkg::SINGLE_POS] :
        (sync_master & word_done) ? 1'b0 : // see [R2]
        single_receive_enable;

    wire next_continuous =
        wr_control ? writedata[rx_ctrl_pkg::CONTINUOUS_POS] :
        continuous_receive_enable;

    // Overrun holds until software clears continuous; a new overrun wins.
    wire next_overrun =
        overrun_event ? 1'b1 :
        wr_control & ~next_continuous ? 1'b0 : // see [R9]
        overrun_error_flag;

    wire next_framing = load_event ? frame_error : framing_error_flag; // see [R8]

    // Ninth bit is stored raw; any parity check on it is for software.
    wire next_ninth = load_event ? word[8] : received_ninth_bit; // see [R6] see [R12]

    wire next_full = load_event ? 1'b1 : rd_data ? 1'b0 : buffer_full;

    wire [2:0] irq_events = {overrun_event, framing_event, load_event};
    wire [2:0] irq_clear = wr_status ? writedata[2:0] : 3'h0;
    // A new event in the same cycle as its clear keeps the bit set.
    wire [2:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;
    wire next_irq = |(next_irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus response registers.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= ~(request & waitrequest);
            if (request & waitrequest) begin
                readdata <= read_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control fields written by software.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nine_bit_receive_select <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::NINE_BIT_POS];
            address_detect_enable <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::ADDRESS_DETECT_POS];
        end else if (wr_control) begin
            nine_bit_receive_select <= writedata[rx_ctrl_pkg::NINE_BIT_POS];
            address_detect_enable <= writedata[rx_ctrl_pkg::ADDRESS_DETECT_POS];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            single_receive_enable <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::SINGLE_POS];
            continuous_receive_enable <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::CONTINUOUS_POS];
        end else begin
            single_receive_enable <= next_single;
            continuous_receive_enable <= next_continuous;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_mode <= rx_ctrl_pkg::MODE_RESET[rx_ctrl_pkg::SYNC_MODE_POS];
            master <= rx_ctrl_pkg::MODE_RESET[rx_ctrl_pkg::MASTER_POS];
        end else if (wr_mode) begin
            sync_mode <= writedata[rx_ctrl_pkg::SYNC_MODE_POS];
            master <= writedata[rx_ctrl_pkg::MASTER_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags and receive buffer.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            framing_error_flag <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::FRAMING_POS];
            overrun_error_flag <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::OVERRUN_POS];
            received_ninth_bit <= rx_ctrl_pkg::CONTROL_RESET[rx_ctrl_pkg::NINTH_BIT_POS];
        end else begin
            framing_error_flag <= next_framing;
            overrun_error_flag <= next_overrun;
            received_ninth_bit <= next_ninth;
        end
    end

    // The overrun word is dropped so the unread word stays intact.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            receive_data_register <= 8'h00;
            buffer_full <= 1'b0;
        end else begin
            buffer_full <= next_full;
            if (load_event) begin
                receive_data_register <= word[7:0]; // see [R5] see [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= rx_ctrl_pkg::IRQ_RESET;
            irq_mask <= rx_ctrl_pkg::IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= writedata[2:0];
            end
        end
    end

    // Registered so the line cannot glitch; it is built from the next status value, so it changes in the same cycle as the status bit.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift engine.

    serial_shift_receiver shifter (
        .clk(clk),
        .nrst(nrst),
        .enable(receiver_on),
        .sync_mode(sync_mode),
        .master(master),
        .nine_bit(nine_bit_receive_select),
        .data_in(rx_data_in),
        .sclk_in(sclk_in),
        .sclk_out(sclk_out),
        .sclk_oe(sclk_oe),
        .word_done(word_done),
        .word(word),
        .frame_error(frame_error)
    );

endmodule
`default_nettype wire

// >>> tb/serial_receive_control_status_asserts.sv
// Port-level assertions for the receive control block.
`timescale 1ns/10ps
`default_nettype none
module serial_receive_control_status_asserts (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Clock pin enable and interrupt.
    input wire logic sclk_oe,
    input wire logic irq
);
    logic [1:0] mode_sh;
    logic [2:0] mask_sh;
    logic [3:0] ctl_sh;
    wire wr_acc = write && !waitrequest;
    wire on_sh = ctl_sh[2] || ctl_sh[1];
    wire master_sh = mode_sh == 2'h3;
    wire mapped = address inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of what software wrote; the hardware clear of single receive is not
    // tracked, so only software-owned fields are compared.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_sh <= 2'h0;
            mask_sh <= 3'h0;
            ctl_sh <= 4'h0;
        end else if (wr_acc) begin
            if (address == rx_ctrl_pkg::ADDR_MODE) mode_sh <= writedata[1:0];
            if (address == rx_ctrl_pkg::ADDR_IRQ_MASK) mask_sh <= writedata[2:0];
            if (address == rx_ctrl_pkg::ADDR_CONTROL_STATUS) ctl_sh <= writedata[6:3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_wait_pulse: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in the next cycle");
    a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("waitrequest dropped without a request");
    a_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_unmapped_zero: assert property (read && waitrequest && !mapped |=> readdata == 32'h0)
        else $error("unmapped read returned nonzero");
    a_mode_back: assert property (read && waitrequest && address == 8'h08
        |=> readdata[1:0] == mode_sh)
        else $error("mode register readback differs");
    a_ctrl_back: assert property (read && waitrequest && address == 8'h00 |=>
        {readdata[7:6], readdata[4:3]} == {1'b0, ctl_sh[3], ctl_sh[1:0]})
        else $error("control field readback differs");
    a_master_only: assert property (sclk_oe |-> master_sh || $past(master_sh))
        else $error("clock pin driven outside synchronous master mode");
    a_recv_off: assert property (!on_sh && $past(!on_sh) |-> !sclk_oe)
        else $error("receiver clock running with both enables clear");
    a_irq_masked: assert property (mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !irq)
        else $error("interrupt raised while fully masked");
    a_rdata_hold: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
        else $error("read data changed between requests");
endmodule
`default_nettype wire

// >>> tb/remote_transmitter.sv
// Model of the remote transmitter that drives the device's receive line.
`timescale 1ns/10ps
`default_nettype none
module remote_transmitter (
    // Clock.
    input wire logic clk,
    // Device clock pin, used in synchronous master mode.
    input wire logic sclk_out,
    input wire logic sclk_oe,
    // Receive line towards the device.
    output logic rx_data_in
);
    logic sync_on = 1'b0;
    logic [8:0] sync_word = 9'h000;
    logic [2:0] idx = 3'h0;
    logic sclk_prev = 1'b0;
    initial rx_data_in = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // A low stop ends early so it is not taken for a new start.
    task automatic send_async(input logic [8:0] w, input int nb, input logic stop);
        rx_data_in <= 1'b0;
        repeat (rx_ctrl_pkg::BIT_CYCLES) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rx_data_in <= w[i];
            repeat (rx_ctrl_pkg::BIT_CYCLES) @(posedge clk);
        end
        rx_data_in <= stop;
        repeat (rx_ctrl_pkg::BIT_CYCLES - 4) @(posedge clk);
        rx_data_in <= 1'b1;
        repeat (rx_ctrl_pkg::BIT_CYCLES + 4) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bits change after the falling device clock so they are settled at its rise.
    always @(posedge clk) begin
        sclk_prev <= sclk_out;
        if (sync_on && !sclk_oe) begin
            idx <= 3'h0;
            rx_data_in <= sync_word[0];
        end else if (sync_on && sclk_prev && !sclk_out) begin
            idx <= idx + 3'h1;
            rx_data_in <= sync_word[idx + 3'h1];
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the receive control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [7:0] CTL = rx_ctrl_pkg::ADDR_CONTROL_STATUS;
    localparam logic [7:0] DAT = rx_ctrl_pkg::ADDR_RECEIVE_DATA;
    localparam logic [7:0] MODE = rx_ctrl_pkg::ADDR_MODE;
    localparam logic [7:0] IST = rx_ctrl_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] MSK = rx_ctrl_pkg::ADDR_IRQ_MASK;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    wire rx_data_in;
    logic sclk_in = 1'b0;
    logic sclk_out;
    logic sclk_oe;
    logic irq;
    int n_fail = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    serial_receive_control_status uut (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_data_in(rx_data_in), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .irq(irq));
    remote_transmitter far (.clk(clk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .rx_data_in(rx_data_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // An edge passes between requests, so no strobe is set twice.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = readdata;
        if (n == 20) check(32'h1, 32'h0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        expect_reg(CTL, 32'h0);
        expect_reg(MODE, 32'h0);
        expect_reg(IST, 32'h0);
        expect_reg(MSK, 32'h0);
        wr(8'h14, 32'hff);
        expect_reg(8'h14, 32'h0);
        expect_reg(CTL, 32'h0);
        wr(MSK, 32'h7);
        expect_reg(MSK, 32'h7);
        wr(MSK, 32'h0);
    endtask

    task automatic t_async();
        wr(CTL, 32'h10);
        far.send_async(9'h0a5, 8, 1'b1);
        expect_reg(DAT, 32'ha5);
        expect_reg(CTL, 32'h10);
        wr(CTL, 32'h50);
        far.send_async({^8'h3d, 8'h3d}, 9, 1'b1);
        expect_reg(DAT, 32'h3d);
        expect_reg(CTL, 32'h51);
        wr(IST, 32'h7);
        wr(CTL, 32'h60);
        far.send_async(9'h0e7, 8, 1'b1);
        expect_reg(IST, 32'h0);
        wr(CTL, 32'h0);
    endtask

    task automatic t_addr();
        wr(IST, 32'h7);
        wr(CTL, 32'h58);
        far.send_async(9'h055, 9, 1'b1);
        expect_reg(IST, 32'h0);
        far.send_async(9'h1aa, 9, 1'b1);
        expect_reg(IST, 32'h1);
        expect_reg(DAT, 32'haa);
        expect_reg(CTL, 32'h59);
        wr(CTL, 32'h18);
        far.send_async(9'h055, 8, 1'b1);
        expect_reg(DAT, 32'h55);
    endtask

    task automatic t_frame();
        wr(CTL, 32'h10);
        wr(IST, 32'h7);
        far.send_async(9'h081, 8, 1'b0);
        expect_reg(CTL, 32'h14);
        expect_reg(IST, 32'h3);
        expect_reg(DAT, 32'h81);
        far.send_async(9'h07e, 8, 1'b1);
        expect_reg(CTL, 32'h10);
        expect_reg(DAT, 32'h7e);
    endtask

    task automatic t_overrun();
        wr(IST, 32'h7);
        wr(MSK, 32'h4);
        far.send_async(9'h011, 8, 1'b1);
        check({31'h0, irq}, 32'h0);
        far.send_async(9'h022, 8, 1'b1);
        check({31'h0, irq}, 32'h1);
        expect_reg(CTL, 32'h12);
        expect_reg(DAT, 32'h11);
        expect_reg(CTL, 32'h12);
        wr(IST, 32'h4);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(CTL, 32'h0);
        expect_reg(CTL, 32'h0);
        wr(MSK, 32'h0);
    endtask

    task automatic t_sync();
        far.sync_word = 9'h0c3;
        far.sync_on = 1'b1;
        wr(MODE, 32'h3);
        wr(IST, 32'h7);
        wr(CTL, 32'h20);
        repeat (160) @(posedge clk);
        expect_reg(CTL, 32'h0);
        expect_reg(DAT, 32'hc3);
        check({31'h0, sclk_oe}, 32'h0);
        wr(IST, 32'h7);
        wr(CTL, 32'h30);
        repeat (150) @(posedge clk);
        expect_reg(DAT, 32'hc3);
        expect_reg(CTL, 32'h10);
        wr(IST, 32'h1);
        repeat (130) @(posedge clk);
        expect_reg(IST, 32'h1);
        check({31'h0, sclk_oe}, 32'h1);
        expect_reg(DAT, 32'hc3);
        wr(CTL, 32'h0);
        repeat (4) @(posedge clk);
        check({30'h0, sclk_out, sclk_oe}, 32'h0);
    endtask

    task automatic t_slave();
        wr(MODE, 32'h1);
        wr(IST, 32'h7);
        wr(CTL, 32'h20);
        repeat (160) @(posedge clk);
        expect_reg(IST, 32'h0);
        expect_reg(CTL, 32'h20);
        check({31'h0, sclk_oe}, 32'h0);
        wr(CTL, 32'h10);
        repeat (16) @(posedge clk) sclk_in <= ~sclk_in;
        expect_reg(DAT, 32'hff);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_async();
        t_addr();
        t_frame();
        t_overrun();
        t_sync();
        t_slave();
        final_report();
    end

    // Roughly seven and a half times the run length.
    initial begin
        #(20000 * 25);
        n_fail++;
        final_report();
    end
endmodule

bind serial_receive_control_status serial_receive_control_status_asserts chk (.clk(clk),
    .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .sclk_oe(sclk_oe), .irq(irq));
`default_nettype wire
